// ---- frame_assembler.sv ----
// Purpose: device end, maps dual-band complex samples onto octet lanes
// Assumes: samples arrive on i_sample_valid, taken when o_sample_ready
// Notes: configuration is captured only on a link start pulse
//
// What this block does
// - Two bands per channel, nine decimation settings
// - Eight-lane format: 20X multiplier, select 1,0,0
// - Four-lane format: 40X multiplier, select 2,0,0
// - Lane rate is clock times multiplier over decimation
// - Decimation 24 and 32 allow four-lane only
// - Eight-lane: one sample per lane, high octet first
// - Four-lane: lanes 1,2 carry I then Q
// - Channel B mirrors channel A lane arrangement
`timescale 1ns/1ps
module frame_assembler (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic [1:0] i_link_format_select_0,
  input wire logic [1:0] i_link_format_select_1,
  input wire logic [1:0] i_link_format_select_2,
  input frame_assembly_pkg::pll_mult_t i_pll_mult,
  input frame_assembly_pkg::decim_t i_decimation,
  input wire logic i_link_start,
  input wire logic i_link_stop,
  input frame_assembly_pkg::chan_samples_t i_chan_a_samples,
  input frame_assembly_pkg::chan_samples_t i_chan_b_samples,
  input wire logic i_sample_valid,
  output logic o_sample_ready,
  output logic o_link_up,
  output logic o_cfg_error,
  output logic [15:0] o_rate_ratio_x100,
  lane_link_if.device link
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {st_down, st_idle, st_send} fa_state_t;

  fa_state_t state_r;
  fa_state_t state_nxt;
  logic four_lane_r;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic [1:0] last_octet;
  logic accept;
  logic cfg_eight_ok;
  logic cfg_four_ok;
  logic cfg_ok;
  logic [5:0] factor;
  logic [15:0] mult_x100;
  frame_assembly_pkg::chan_samples_t smp_r [2];
  frame_assembly_pkg::chan_samples_t smp_nxt [2];
  logic [7:0] lane_r [2][frame_assembly_pkg::LANES_PER_CHAN];
  logic valid_r;
  logic start_r;
  logic restart_r;

  // Pick one octet of a lane from a channel's four samples
  function automatic logic [7:0] lane_octet(
    input frame_assembly_pkg::chan_samples_t s,
    input logic four,
    input logic [1:0] lane,
    input logic [1:0] idx
  );
    logic [15:0] w;
    w = 16'h0000;
    if (!four) begin
      w = s[lane];
    end else if (lane == 2'h1) begin
      w = idx[1] ? s[1] : s[0];
    end else if (lane == 2'h2) begin
      w = idx[1] ? s[3] : s[2];
    end else begin
      w = 16'h0000;
    end
    return idx[0] ? w[7:0] : w[15:8];
  endfunction

  // ----------------------------------------------------------------
  // Configuration check
  // ----------------------------------------------------------------
  // Legal decimation and format combinations
  always_comb begin
    factor = frame_assembly_pkg::decim_factor(i_decimation);
    cfg_eight_ok = (i_link_format_select_0 ==
                    frame_assembly_pkg::SEL0_EIGHT_LANE) &&
                   (i_link_format_select_1 ==
                    frame_assembly_pkg::SEL_OTHER_CODE) &&
                   (i_link_format_select_2 ==
                    frame_assembly_pkg::SEL_OTHER_CODE) &&
                   (i_pll_mult == frame_assembly_pkg::pll_20x) &&
                   (i_decimation != frame_assembly_pkg::dec_24) &&
                   (i_decimation != frame_assembly_pkg::dec_32);
    cfg_four_ok = (i_link_format_select_0 ==
                   frame_assembly_pkg::SEL0_FOUR_LANE) &&
                  (i_link_format_select_1 ==
                   frame_assembly_pkg::SEL_OTHER_CODE) &&
                  (i_link_format_select_2 ==
                   frame_assembly_pkg::SEL_OTHER_CODE) &&
                  (i_pll_mult == frame_assembly_pkg::pll_40x);
    cfg_ok = (factor != 6'h00) && (cfg_eight_ok || cfg_four_ok);
    mult_x100 = (i_pll_mult == frame_assembly_pkg::pll_40x) ?
                frame_assembly_pkg::MULT_40X_X100 :
                frame_assembly_pkg::MULT_20X_X100;
  end

  // Format and ratio are captured only on a start pulse
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      four_lane_r <= 1'b0;
      o_cfg_error <= 1'b0;
      o_rate_ratio_x100 <= 16'h0000;
    end else if (i_link_start) begin
      four_lane_r <= cfg_four_ok;
      o_cfg_error <= !cfg_ok;
      if (cfg_ok) begin
        o_rate_ratio_x100 <= mult_x100 / {10'h000, factor};
      end else begin
        o_rate_ratio_x100 <= 16'h0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame sequencing
  // ----------------------------------------------------------------
  assign last_octet = four_lane_r ? frame_assembly_pkg::LAST_OCTET_FOUR :
                      frame_assembly_pkg::LAST_OCTET_EIGHT;
  assign accept = o_sample_ready && i_sample_valid;

  // Next state and octet index
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      st_down: begin
        cnt_nxt = 2'h0;
        if (restart_r) begin
          state_nxt = st_idle;
        end
      end
      st_idle: begin
        cnt_nxt = 2'h0;
        if (accept) begin
          state_nxt = st_send;
        end
      end
      st_send: begin
        if (cnt_r != last_octet) begin
          cnt_nxt = cnt_r + 2'h1;
        end else if (accept) begin
          cnt_nxt = 2'h0;
        end else begin
          state_nxt = st_idle;
          cnt_nxt = 2'h0;
        end
      end
      default: begin
        state_nxt = st_down;
        cnt_nxt = 2'h0;
      end
    endcase
    if (i_link_stop || i_link_start) begin
      state_nxt = st_down;
      cnt_nxt = 2'h0;
    end
  end

  // State, index and ready flag
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r <= st_down;
      cnt_r <= 2'h0;
      o_sample_ready <= 1'b0;
      o_link_up <= 1'b0;
      restart_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      o_sample_ready <= (state_nxt == st_idle) ||
                        ((state_nxt == st_send) && (cnt_nxt == last_octet));
      o_link_up <= (state_nxt != st_down);
      // A legal start is remembered across its forced down cycle
      restart_r <= i_link_start && cfg_ok && !i_link_stop;
    end
  end

  // ----------------------------------------------------------------
  // Sample capture and lane octets
  // ----------------------------------------------------------------
  // Start restarts the link, so a start cycle never sends
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      valid_r <= 1'b0;
      start_r <= 1'b0;
    end else begin
      valid_r <= (state_nxt == st_send);
      start_r <= accept && !i_link_stop && !i_link_start;
    end
  end

  // Both channels share one arrangement
  for (genvar c = 0; c < 2; c++) begin : g_chan
    always_comb begin
      smp_nxt[c] = smp_r[c];
      if (accept) begin
        smp_nxt[c] = (c == 0) ? i_chan_a_samples : i_chan_b_samples;
      end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
        smp_r[c] <= '0;
      end else begin
        smp_r[c] <= smp_nxt[c];
      end
    end

    for (genvar k = 0; k < frame_assembly_pkg::LANES_PER_CHAN; k++)
    begin : g_lane
      always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
          lane_r[c][k] <= 8'h00;
        end else if (state_nxt == st_send) begin
          lane_r[c][k] <= lane_octet(smp_nxt[c], four_lane_r, 2'(k),
                                     cnt_nxt);
        end else begin
          lane_r[c][k] <= 8'h00;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Link outputs
  // ----------------------------------------------------------------
  assign link.chan_a_lane_0 = lane_r[0][0];
  assign link.chan_a_lane_1 = lane_r[0][1];
  assign link.chan_a_lane_2 = lane_r[0][2];
  assign link.chan_a_lane_3 = lane_r[0][3];
  assign link.chan_b_lane_0 = lane_r[1][0];
  assign link.chan_b_lane_1 = lane_r[1][1];
  assign link.chan_b_lane_2 = lane_r[1][2];
  assign link.chan_b_lane_3 = lane_r[1][3];
  assign link.octet_valid = valid_r;
  assign link.frame_start = start_r;
  assign link.four_lane = four_lane_r;
  assign link.link_up = o_link_up;

endmodule

// ---- frame_assembly_pkg.sv ----
// Purpose: shared constants and types for the dual-band complex framer
// Assumes: one octet per lane per clock on the parallel link side
// Notes: sample index 0 = band 1 I, 1 = band 1 Q, 2 = band 2 I, 3 = band 2 Q
package frame_assembly_pkg;

  // ----------------------------------------------------------------
  // Format select codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL0_EIGHT_LANE = 2'h1;
  localparam logic [1:0] SEL0_FOUR_LANE = 2'h2;
  localparam logic [1:0] SEL_OTHER_CODE = 2'h0;

  // ----------------------------------------------------------------
  // Frame geometry and rate
  // ----------------------------------------------------------------
  localparam logic [1:0] LAST_OCTET_EIGHT = 2'h1;
  localparam logic [1:0] LAST_OCTET_FOUR = 2'h3;
  localparam logic [15:0] MULT_20X_X100 = 16'h07d0;
  localparam logic [15:0] MULT_40X_X100 = 16'h0fa0;
  localparam int SAMPLES_PER_CHAN = 4;
  localparam int LANES_PER_CHAN = 4;

  // ----------------------------------------------------------------
  // Configuration types
  // ----------------------------------------------------------------
  typedef enum logic {pll_20x, pll_40x} pll_mult_t;

  typedef enum logic [3:0] {
    dec_8, dec_9, dec_10, dec_12, dec_16, dec_18, dec_20, dec_24, dec_32,
    dec_bad_9, dec_bad_10, dec_bad_11, dec_bad_12, dec_bad_13,
    dec_bad_14, dec_bad_15
  } decim_t;

  typedef logic [SAMPLES_PER_CHAN-1:0][15:0] chan_samples_t;

  // Decimation factor, zero for an unsupported code
  function automatic logic [5:0] decim_factor(input decim_t d);
    logic [5:0] f;
    f = 6'h00;
    case (d)
      dec_8: f = 6'h08;
      dec_9: f = 6'h09;
      dec_10: f = 6'h0a;
      dec_12: f = 6'h0c;
      dec_16: f = 6'h10;
      dec_18: f = 6'h12;
      dec_20: f = 6'h14;
      dec_24: f = 6'h18;
      dec_32: f = 6'h20;
      default: f = 6'h00;
    endcase
    return f;
  endfunction

endpackage

// ---- lane_link_if.sv ----
// Purpose: parallel octet lanes between framer and receiver logic
// Assumes: both ends share one clock
// Notes: each lane carries one octet per clock while octet_valid is high
`timescale 1ns/1ps
interface lane_link_if;
  logic [7:0] chan_a_lane_0;
  logic [7:0] chan_a_lane_1;
  logic [7:0] chan_a_lane_2;
  logic [7:0] chan_a_lane_3;
  logic [7:0] chan_b_lane_0;
  logic [7:0] chan_b_lane_1;
  logic [7:0] chan_b_lane_2;
  logic [7:0] chan_b_lane_3;
  logic octet_valid;
  logic frame_start;
  logic four_lane;
  logic link_up;

  modport device (
    output chan_a_lane_0, chan_a_lane_1, chan_a_lane_2, chan_a_lane_3,
    output chan_b_lane_0, chan_b_lane_1, chan_b_lane_2, chan_b_lane_3,
    output octet_valid, frame_start, four_lane, link_up
  );

  modport host (
    input chan_a_lane_0, chan_a_lane_1, chan_a_lane_2, chan_a_lane_3,
    input chan_b_lane_0, chan_b_lane_1, chan_b_lane_2, chan_b_lane_3,
    input octet_valid, frame_start, four_lane, link_up
  );
endinterface

// ---- frame_receiver.sv ----
// Purpose: far end, rebuilds dual-band complex samples from octet lanes
// Assumes: format follows the four_lane flag sent with the link
// Notes: o_sample_valid pulses one cycle after the last octet of a frame
`timescale 1ns/1ps
module frame_receiver (
  input wire logic i_clock,
  input wire logic i_reset_n,
  lane_link_if.host link,
  output frame_assembly_pkg::chan_samples_t o_chan_a_samples,
  output frame_assembly_pkg::chan_samples_t o_chan_b_samples,
  output logic o_sample_valid,
  output logic o_frame_error
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [1:0] cnt_r;
  logic [1:0] idx;
  logic [1:0] last_octet;
  logic frame_end;
  logic [7:0] lane_in [2][frame_assembly_pkg::LANES_PER_CHAN];
  logic [23:0] sh_r [2][frame_assembly_pkg::LANES_PER_CHAN];

  assign lane_in[0][0] = link.chan_a_lane_0;
  assign lane_in[0][1] = link.chan_a_lane_1;
  assign lane_in[0][2] = link.chan_a_lane_2;
  assign lane_in[0][3] = link.chan_a_lane_3;
  assign lane_in[1][0] = link.chan_b_lane_0;
  assign lane_in[1][1] = link.chan_b_lane_1;
  assign lane_in[1][2] = link.chan_b_lane_2;
  assign lane_in[1][3] = link.chan_b_lane_3;

  // ----------------------------------------------------------------
  // Octet position within the frame
  // ----------------------------------------------------------------
  assign last_octet = link.four_lane ? frame_assembly_pkg::LAST_OCTET_FOUR :
                      frame_assembly_pkg::LAST_OCTET_EIGHT;
  assign idx = link.frame_start ? 2'h0 : cnt_r;
  assign frame_end = link.octet_valid && (idx == last_octet);

  // Count octets, flag a frame start at the wrong place
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_r <= 2'h0;
      o_frame_error <= 1'b0;
    end else begin
      if (!link.link_up) begin
        cnt_r <= 2'h0;
      end else if (link.octet_valid) begin
        cnt_r <= frame_end ? 2'h0 : idx + 2'h1;
      end
      o_frame_error <= link.octet_valid &&
                       (link.frame_start != (cnt_r == 2'h0));
    end
  end

  // ----------------------------------------------------------------
  // Sample rebuild, same arrangement on both channels
  // ----------------------------------------------------------------
  for (genvar c = 0; c < 2; c++) begin : g_chan
    for (genvar k = 0; k < frame_assembly_pkg::LANES_PER_CHAN; k++)
    begin : g_lane
      // High octet arrives first
      always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
          sh_r[c][k] <= 24'h000000;
        end else if (link.octet_valid) begin
          sh_r[c][k] <= {sh_r[c][k][15:0], lane_in[c][k]};
        end
      end
    end
  end

  // Assemble band I and Q words at frame end
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_chan_a_samples <= '0;
      o_chan_b_samples <= '0;
      o_sample_valid <= 1'b0;
    end else begin
      o_sample_valid <= frame_end;
      if (frame_end && !link.four_lane) begin
        for (int k = 0; k < 4; k++) begin
          o_chan_a_samples[k] <= {sh_r[0][k][7:0], lane_in[0][k]};
          o_chan_b_samples[k] <= {sh_r[1][k][7:0], lane_in[1][k]};
        end
      end else if (frame_end) begin
        o_chan_a_samples[0] <= sh_r[0][1][23:8];
        o_chan_a_samples[1] <= {sh_r[0][1][7:0], lane_in[0][1]};
        o_chan_a_samples[2] <= sh_r[0][2][23:8];
        o_chan_a_samples[3] <= {sh_r[0][2][7:0], lane_in[0][2]};
        o_chan_b_samples[0] <= sh_r[1][1][23:8];
        o_chan_b_samples[1] <= {sh_r[1][1][7:0], lane_in[1][1]};
        o_chan_b_samples[2] <= sh_r[1][2][23:8];
        o_chan_b_samples[3] <= {sh_r[1][2][7:0], lane_in[1][2]};
      end
    end
  end

endmodule

// ---- frame_link_props.sv ----
// Purpose: watches the octet lanes between framer and receiver
// Assumes: one clock, reset asynchronous active low
// Notes: instantiated beside the link interface in tb
`timescale 1ns/1ps
module frame_link_props (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic [7:0] chan_a_lane_0,
  input wire logic [7:0] chan_a_lane_1,
  input wire logic [7:0] chan_a_lane_2,
  input wire logic [7:0] chan_a_lane_3,
  input wire logic [7:0] chan_b_lane_0,
  input wire logic [7:0] chan_b_lane_1,
  input wire logic [7:0] chan_b_lane_2,
  input wire logic [7:0] chan_b_lane_3,
  input wire logic octet_valid,
  input wire logic frame_start,
  input wire logic four_lane,
  input wire logic link_up
);
  logic [63:0] lanes_w;
  logic [1:0] four_left_r;

  // All lanes gathered for idle checks
  assign lanes_w = {chan_b_lane_3, chan_b_lane_2, chan_b_lane_1,
    chan_b_lane_0, chan_a_lane_3, chan_a_lane_2, chan_a_lane_1,
    chan_a_lane_0};

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);

  // ----------------------------------------------------------------
  // Framing
  // ----------------------------------------------------------------
  // Octets still owed by a four-lane frame, dropped when the link falls
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      four_left_r <= 2'h0;
    end else if (frame_start && four_lane) begin
      four_left_r <= 2'h3;
    end else if (!link_up || four_left_r == 2'h0) begin
      four_left_r <= 2'h0;
    end else begin
      four_left_r <= four_left_r - 2'h1;
    end
  end

  chk_start_valid: assert property (
    frame_start |-> octet_valid && link_up) else $error("start bad");
  chk_first_octet: assert property (
    $rose(octet_valid) |-> frame_start) else $error("no start");
  chk_eight_pair: assert property (
    frame_start && !four_lane |=> !link_up || octet_valid && !frame_start)
    else $error("eight short");
  chk_eight_end: assert property (
    octet_valid && !frame_start && !four_lane |=> !octet_valid ||
    frame_start) else $error("eight long");
  chk_four_span: assert property (
    four_left_r != 2'h0 && link_up |-> octet_valid && !frame_start)
    else $error("four short");
  chk_four_unused: assert property (
    octet_valid && four_lane |-> lanes_w[7:0] == 8'h00 &&
    lanes_w[31:24] == 8'h00 && lanes_w[39:32] == 8'h00 &&
    lanes_w[63:56] == 8'h00) else $error("unused lane");
  chk_idle_zero: assert property (
    !octet_valid |-> lanes_w == 64'h0) else $error("idle lanes");
  chk_format_hold: assert property (
    link_up && $past(link_up) |-> $stable(four_lane))
    else $error("format moved");
endmodule

// ---- tb.sv ----
// Purpose: drives framer and receiver joined by the octet link
// Assumes: inputs change 1 ns after the rising edge
// Notes: a monitor records every octet seen on the lanes
`timescale 1ns/1ps
module tb;
  logic i_clock;
  logic i_reset_n;
  logic [1:0] sel0, sel1, sel2;
  frame_assembly_pkg::pll_mult_t mult;
  frame_assembly_pkg::decim_t decim;
  logic start, stop, valid, ready, up, cfg_err, rx_valid, frame_err;
  logic [63:0] tx_a, tx_b, rx_a, rx_b;
  logic [63:0] sa [2];
  logic [63:0] sb [2];
  logic [15:0] ratio;
  logic [63:0] wq [$];
  logic fq [$];
  logic [127:0] rq [$];
  int n_mismatch;
  int tests_run;
  int n_ferr;

  lane_link_if link ();

  frame_assembler i_frame_assembler (.i_clock(i_clock),
    .i_reset_n(i_reset_n), .i_link_format_select_0(sel0),
    .i_link_format_select_1(sel1), .i_link_format_select_2(sel2),
    .i_pll_mult(mult), .i_decimation(decim), .i_link_start(start),
    .i_link_stop(stop), .i_chan_a_samples(tx_a),
    .i_chan_b_samples(tx_b), .i_sample_valid(valid),
    .o_sample_ready(ready), .o_link_up(up), .o_cfg_error(cfg_err),
    .o_rate_ratio_x100(ratio), .link(link));
  frame_receiver i_frame_receiver (.i_clock(i_clock),
    .i_reset_n(i_reset_n), .link(link), .o_chan_a_samples(rx_a),
    .o_chan_b_samples(rx_b), .o_sample_valid(rx_valid),
    .o_frame_error(frame_err));
  frame_link_props u_props (.i_clock(i_clock), .i_reset_n(i_reset_n),
    .chan_a_lane_0(link.chan_a_lane_0), .chan_a_lane_1(link.chan_a_lane_1),
    .chan_a_lane_2(link.chan_a_lane_2), .chan_a_lane_3(link.chan_a_lane_3),
    .chan_b_lane_0(link.chan_b_lane_0), .chan_b_lane_1(link.chan_b_lane_1),
    .chan_b_lane_2(link.chan_b_lane_2), .chan_b_lane_3(link.chan_b_lane_3),
    .octet_valid(link.octet_valid), .frame_start(link.frame_start),
    .four_lane(link.four_lane), .link_up(link.link_up));

  // Clock and watchdog
  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end
  initial begin
    #200000;
    n_mismatch++;
    tally_and_finish();
  end

  // Record lane octets and rebuilt sample sets
  always @(negedge i_clock) begin
    if (link.octet_valid === 1'b1) begin
      wq.push_back({link.chan_b_lane_3, link.chan_b_lane_2,
        link.chan_b_lane_1, link.chan_b_lane_0, link.chan_a_lane_3,
        link.chan_a_lane_2, link.chan_a_lane_1, link.chan_a_lane_0});
      fq.push_back(link.frame_start);
    end
    if (rx_valid === 1'b1) rq.push_back({rx_b, rx_a});
    if (frame_err !== 1'b0) n_ferr++;
  end

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Expected octet of one lane, octet index idx within the frame
  function automatic logic [7:0] exp_oct(input logic [63:0] s,
      input logic four, input int lane, input int idx);
    logic [15:0] w;
    w = 16'h0000;
    if (!four) w = s[lane*16 +: 16];
    else if (lane == 1 || lane == 2) w = s[((lane-1)*2+idx/2)*16 +: 16];
    return (idx % 2 == 0) ? w[15:8] : w[7:0];
  endfunction

  function automatic logic [63:0] mk(input int seed);
    logic [63:0] s;
    for (int k = 0; k < 4; k++) s[k*16 +: 16] = 16'((seed*4+k+1)*4951+7);
    return s;
  endfunction

  // Start pulse with a configuration, then judge the answer
  task automatic cfg(input logic [1:0] s0, input logic [1:0] s1,
      input logic [1:0] s2, input logic m, input logic [3:0] d,
      input logic err, input logic [15:0] r);
    sel0 = s0;
    sel1 = s1;
    sel2 = s2;
    mult = frame_assembly_pkg::pll_mult_t'(m);
    decim = frame_assembly_pkg::decim_t'(d);
    start = 1'b1;
    @(posedge i_clock);
    #1 start = 1'b0;
    check(128'(cfg_err), 128'(err));
    check(128'(ratio), 128'(r));
    check(128'(up), 128'h0);
    @(posedge i_clock);
    #1 check(128'(up), 128'(!err));
    check(128'(ready), 128'(!err));
    if (!err) check(128'(link.four_lane), 128'(s0 == 2'h2));
  endtask

  // Offer one sample set and hold it until taken
  task automatic push(input logic [63:0] a, input logic [63:0] b);
    int n;
    tx_a = a;
    tx_b = b;
    valid = 1'b1;
    n = 0;
    @(negedge i_clock);
    while (ready !== 1'b1 && n < 20) begin
      @(negedge i_clock);
      n++;
    end
    check(128'(n < 20), 128'h1);
    @(posedge i_clock);
    #1;
  endtask

  // Two back-to-back frames, checked on the lanes and at the receiver
  task automatic frames(input logic four);
    int no;
    logic full;
    logic [7:0] ea, eb;
    no = four ? 4 : 2;
    for (int f = 0; f < 2; f++) begin
      sa[f] = mk(f * 2 + four);
      sb[f] = mk(f * 2 + four + 8);
    end
    wq.delete();
    fq.delete();
    rq.delete();
    push(sa[0], sb[0]);
    push(sa[1], sb[1]);
    valid = 1'b0;
    repeat (10) @(posedge i_clock);
    #1 check(128'(wq.size()), 128'(2 * no));
    full = (wq.size() == 2 * no);
    for (int f = 0; f < 2 && full; f++)
      for (int i = 0; i < no; i++) begin
        for (int l = 0; l < 4; l++) begin
          ea = exp_oct(sa[f], four, l, i);
          eb = exp_oct(sb[f], four, l, i);
          check(128'(wq[0][l*8 +: 8]), 128'(ea));
          check(128'(wq[0][32+l*8 +: 8]), 128'(eb));
        end
        check(128'(fq.pop_front()), 128'(i == 0));
        void'(wq.pop_front());
      end
    check(128'(rq.size()), 128'h2);
    for (int f = 0; f < 2 && rq.size() > 0; f++)
      check(rq.pop_front(), {sb[f], sa[f]});
    check(128'(n_ferr), 128'h0);
  endtask

  task automatic t_rates();
    int fac [9];
    int r;
    logic bad;
    logic [1:0] s0;
    fac = '{8, 9, 10, 12, 16, 18, 20, 24, 32};
    for (int d = 0; d < 9; d++)
      for (int f = 0; f < 2; f++) begin
        bad = f == 0 && d >= 7;
        s0 = f ? 2'h2 : 2'h1;
        r = bad ? 0 : (f ? 4000 : 2000) / fac[d];
        cfg(s0, 2'h0, 2'h0, f[0], d[3:0], bad, 16'(r));
      end
    cfg(2'h1, 2'h0, 2'h0, 1'b1, 4'h0, 1'b1, 16'h0000);
    cfg(2'h1, 2'h1, 2'h0, 1'b0, 4'h0, 1'b1, 16'h0000);
    cfg(2'h2, 2'h0, 2'h0, 1'b0, 4'h0, 1'b1, 16'h0000);
    cfg(2'h2, 2'h0, 2'h1, 1'b1, 4'h0, 1'b1, 16'h0000);
    cfg(2'h2, 2'h0, 2'h0, 1'b1, 4'h9, 1'b1, 16'h0000);
    $display("test rates done");
  endtask

  task automatic t_frames();
    cfg(2'h1, 2'h0, 2'h0, 1'b0, 4'h2, 1'b0, 16'h00c8);
    frames(1'b0);
    cfg(2'h2, 2'h0, 2'h0, 1'b1, 4'h8, 1'b0, 16'h007d);
    frames(1'b1);
    $display("test frames done");
  endtask

  // Config moved without a start, then stop and a refused offer
  task automatic t_hold();
    sel0 = 2'h1;
    mult = frame_assembly_pkg::pll_20x;
    repeat (3) @(posedge i_clock);
    #1 check(128'(link.four_lane), 128'h1);
    check(128'(ratio), 128'h007d);
    frames(1'b1);
    stop = 1'b1;
    @(posedge i_clock);
    #1 stop = 1'b0;
    check(128'(up), 128'h0);
    wq.delete();
    tx_a = mk(20);
    valid = 1'b1;
    repeat (4) @(posedge i_clock);
    #1 valid = 1'b0;
    check(128'(wq.size()), 128'h0);
    $display("test hold done");
  endtask

  // Reset in mid-run clears link and rate, then a start works again
  task automatic t_reset();
    cfg(2'h1, 2'h0, 2'h0, 1'b0, 4'h0, 1'b0, 16'h00fa);
    i_reset_n = 1'b0;
    @(posedge i_clock);
    #1 i_reset_n = 1'b1;
    check(128'({up, ready, cfg_err}), 128'h0);
    check(128'(ratio), 128'h0000);
    @(posedge i_clock);
    #1 check(128'({up, ready}), 128'h0);
    cfg(2'h2, 2'h0, 2'h0, 1'b1, 4'h0, 1'b0, 16'h01f4);
    $display("test reset done");
  endtask

  initial begin
    i_reset_n = 1'b0;
    {sel0, sel1, sel2, start, stop, valid} = 9'h000;
    mult = frame_assembly_pkg::pll_20x;
    decim = frame_assembly_pkg::dec_8;
    tx_a = 64'h0;
    tx_b = 64'h0;
    n_mismatch = 0;
    tests_run = 0;
    n_ferr = 0;
    repeat (12) @(posedge i_clock);
    #1 i_reset_n = 1'b1;
    check(128'(up), 128'h0);
    t_rates();
    t_frames();
    t_hold();
    t_reset();
    tally_and_finish();
  end
endmodule
